/* File: sel_defs.svh */
`ifndef SEL_DEFS_SVH
`define SEL_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets on the APB port
// ----------------------------------------------------------------
`define SEL_OFS_CTRL      8'h00
`define SEL_OFS_CONFIG    8'h04
`define SEL_OFS_BASE      8'h08
`define SEL_OFS_STA_LOW   8'h0C
`define SEL_OFS_STA_MID   8'h10
`define SEL_OFS_STA_HIGH  8'h14
`define SEL_OFS_GP        8'h18
`define SEL_OFS_PTR       8'h1C

// ----------------------------------------------------------------
// Control register bit positions
// ----------------------------------------------------------------
`define SEL_CTRL_TSEL     0
`define SEL_CTRL_RELOAD   1
`define SEL_CTRL_STORE    2

// ----------------------------------------------------------------
// Memory map of the serial store
// ----------------------------------------------------------------
`define SEL_WA_STA_LOW    6'h20
`define SEL_WA_STA_MID    6'h21
`define SEL_WA_STA_HIGH   6'h22
`define SEL_SEL_FIXED     3'h7
`define SEL_CFG_STRIDE    4

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SEL_CONFIG_RST    16'h0000
`define SEL_BASE_RST      16'h0000
`define SEL_STA_RST       16'h0000

// ----------------------------------------------------------------
// Serial clock: 250 MHz system clock, serial clock at most 1 MHz
// ----------------------------------------------------------------
`define SEL_SYS_MHZ       250
`define SEL_SK_MAX_KHZ    1000
`define SEL_HALF_CYC      ((`SEL_SYS_MHZ * 1000) / (2 * `SEL_SK_MAX_KHZ))
// Chip select low time between commands, 250 ns.
`define SEL_CS_GAP_NS     250
`define SEL_CS_GAP_CYC    ((`SEL_CS_GAP_NS * `SEL_SYS_MHZ + 999) / 1000)

`endif

/* File: sel_nvm_model.sv */
// ----------------------------------------------------------------
// Behavioural three-wire serial store, 64 words of 16 bits
// ----------------------------------------------------------------
module sel_nvm_model #(
  parameter int WR_NS = 1500
) (
  input  wire logic cs_in,
  input  wire logic sk_in,
  input  wire logic di_in,
  output logic      do_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [64];
  logic [24:0] sh;
  logic [8:0]  hdr;
  logic [15:0] rd;
  logic        wen  = 1'b0;
  logic        dbit = 1'b1;
  int          n    = 0;

  // Known contents, so every word read back can be predicted.
  initial begin
    for (int i = 0; i < 64; i++) mem[i] = 16'hC300 | 16'(i);
  end

  // Command bits in on rising clock; a read answers a dummy zero, then the word MSB first.
  always @(posedge sk_in) begin
    if (cs_in) begin
      sh = {sh[23:0], di_in};
      n++;
      if (n == 9) hdr = sh[8:0];
      if (n == 9) rd = mem[sh[5:0]];
      if (n >= 9 && n <= 25 && hdr[7:6] == 2'b10) dbit = (n == 9) ? 1'b0 : rd[25-n];
    end
  end

  // Frame end: latch the enable, or commit a write and stay busy for a while.
  always @(negedge cs_in) begin
    if (n >= 9 && hdr[7:4] == 4'b0011) wen = 1'b1;
    if (n == 25 && hdr[7:6] == 2'b01 && wen) begin
      mem[hdr[5:0]] = sh[15:0];
      dbit = 1'b0;
      dbit <= #(WR_NS) 1'b1;
    end
    n = 0;
  end

  // A deselected part no longer shows its last bit, so a stale sample is caught.
  assign do_out = cs_in ? dbit : ~dbit;
endmodule : sel_nvm_model

/* File: sel_pkg.sv */
package sel_pkg;

  // Command kinds of the three-wire serial store.
  typedef enum logic [1:0] {
    SEL_OP_READ,
    SEL_OP_WRITE,
    SEL_OP_WREN
  } sel_op_t;

  // One request to the serial engine.
  typedef struct packed {
    sel_op_t     op;
    logic [5:0]  addr;
    logic [15:0] data;
  } sel_req_t;

  // Serial pins towards the store.
  typedef struct packed {
    logic cs;
    logic sk;
    logic di;
  } sel_pins_t;

endpackage : sel_pkg

/* File: sel_setup_loader.sv */
// Notes on behaviour
// - After reset, load station address, base and configuration from the store.
// - Configuration word at select value times four, base word at next address.
// - Station address always comes from words 20h, 21h and 22h.
// - Select value seven loads only the station address; others keep defaults.
// - Store is 64 words of 16 bits, every access a whole word.
// - Target select bit: zero normal setup, one general-purpose word access.
// - Normal read updates configuration, base and station address registers.
// - Normal write stores configuration and base at select-chosen words.
// - Control bits 2..0 are store, reload, select; never saved or restored.
// - General read loads the pointed word into the general-purpose register.
// - General write stores the general-purpose register at the pointed word.
// - Software sets a trigger; device clears it when the operation ends.
// - While an operation runs, both trigger bits read back as one.
// - While an operation runs, all other register reads and writes are blocked.
// - With the presence pin low the store is never accessed.
`include "sel_defs.svh"

module sel_setup_loader
  import sel_pkg::*;
#(
  parameter int HALF_CYC = `SEL_HALF_CYC
) (
  input  wire logic        clk_sys_in,
  input  wire logic        arst_n_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic [31:0]      prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic [2:0]  config_select_pins_in,
  input  wire logic        nvm_present_pin_in,
  input  wire logic        nvm_do_in,
  output logic             nvm_cs_out,
  output logic             nvm_sk_out,
  output logic             nvm_di_out,
  output logic [15:0]      config_out,
  output logic [15:0]      base_out,
  output logic [47:0]      station_addr_out,
  output logic             busy_out
);

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {SEL_S_BOOT, SEL_S_IDLE, SEL_S_ISSUE, SEL_S_WAIT, SEL_S_FIN} sel_st_t;

  sel_st_t     state_r;
  logic [2:0]  step_r;
  logic        tsel_r;
  logic        reload_r;
  logic        store_r;
  logic [15:0] config_r;
  logic [15:0] base_r;
  logic [15:0] sta_low_r;
  logic [15:0] sta_mid_r;
  logic [15:0] sta_high_r;
  logic [15:0] gp_r;
  logic [5:0]  ptr_r;
  logic        start_r;
  sel_req_t    req_r;
  sel_pins_t   pins;
  logic [15:0] eng_rdata;
  logic        eng_done;
  logic        busy;
  logic        wr_acc;
  logic        mapped;
  logic [5:0]  cfg_wa;
  logic [2:0]  last_step;
  logic [31:0] rdata_nxt;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Busy covers every store operation, the boot load among them.
  assign busy   = (state_r != SEL_S_IDLE);
  // Each select value owns a slot of four words; the top of the product never exceeds six bits.
  assign cfg_wa = 6'(config_select_pins_in * `SEL_CFG_STRIDE);
  assign mapped = (paddr_in[1:0] == 2'b00) && (paddr_in <= `SEL_OFS_PTR);
  // Other registers refuse access while busy; the error flags the blocked access.
  assign wr_acc = psel_in && penable_in && pwrite_in && !busy && mapped;
  // No register needs a wait state, so every access ends in its first access cycle.
  assign pready_out  = 1'b1;
  assign pslverr_out = psel_in && penable_in && (!mapped || (busy && paddr_in != `SEL_OFS_CTRL));
  assign busy_out    = busy;

  // Normal reads walk config, base, then three station words, select seven skipping the first two; stores end after base.
  assign last_step = (tsel_r) ? 3'd0 : (store_r ? 3'd1 : 3'd4);

  // ----------------------------------------------------------------
  // Read data, registered
  // ----------------------------------------------------------------
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (paddr_in == `SEL_OFS_CTRL) begin
      rdata_nxt[`SEL_CTRL_TSEL]   = tsel_r;
      rdata_nxt[`SEL_CTRL_RELOAD] = reload_r || busy;
      rdata_nxt[`SEL_CTRL_STORE]  = store_r || busy;
    end else if (!busy) begin
      unique case (paddr_in)
        `SEL_OFS_CONFIG:   rdata_nxt[15:0] = config_r;
        `SEL_OFS_BASE:     rdata_nxt[15:0] = base_r;
        `SEL_OFS_STA_LOW:  rdata_nxt[15:0] = sta_low_r;
        `SEL_OFS_STA_MID:  rdata_nxt[15:0] = sta_mid_r;
        `SEL_OFS_STA_HIGH: rdata_nxt[15:0] = sta_high_r;
        `SEL_OFS_GP:       rdata_nxt[15:0] = gp_r;
        `SEL_OFS_PTR:      rdata_nxt[5:0]  = ptr_r;
        default:           rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // Read data changes in the setup phase so it is stable during access.
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      prdata_out <= 32'h0000_0000;
    end else if (psel_in && !penable_in) begin
      prdata_out <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Control bits and trigger handshake
  // ----------------------------------------------------------------
  // The control bits live only in flops and never travel to the store.
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tsel_r   <= 1'b0;
      reload_r <= 1'b0;
      store_r  <= 1'b0;
    end else if (state_r == SEL_S_FIN) begin
      reload_r <= 1'b0;
      store_r  <= 1'b0;
    end else if (wr_acc && paddr_in == `SEL_OFS_CTRL) begin
      tsel_r   <= pwdata_in[`SEL_CTRL_TSEL];
      // Reload wins when both are set in one write.
      // Without a fitted store a trigger is dropped, so polling software never waits forever.
      reload_r <= pwdata_in[`SEL_CTRL_RELOAD] && nvm_present_pin_in;
      store_r  <= pwdata_in[`SEL_CTRL_STORE] && !pwdata_in[`SEL_CTRL_RELOAD] && nvm_present_pin_in;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_r <= SEL_S_BOOT;
      step_r  <= 3'd0;
      start_r <= 1'b0;
      req_r   <= '0;
    end else begin
      start_r <= 1'b0;
      unique case (state_r)
        SEL_S_BOOT: begin
          // Boot load runs as a normal reload, unless no store is fitted.
          if (!nvm_present_pin_in) begin
            state_r <= SEL_S_IDLE;
          end else begin
            step_r  <= (config_select_pins_in == `SEL_SEL_FIXED) ? 3'd2 : 3'd0;
            state_r <= SEL_S_ISSUE;
          end
        end
        SEL_S_IDLE: begin
          if (reload_r) begin
            step_r  <= (!tsel_r && config_select_pins_in == `SEL_SEL_FIXED) ? 3'd2 : 3'd0;
            state_r <= SEL_S_ISSUE;
          end else if (store_r) begin
            // Writes are preceded by a write-enable command.
            step_r  <= 3'd0;
            req_r   <= '{op: SEL_OP_WREN, addr: 6'h00, data: 16'h0000};
            start_r <= 1'b1;
            state_r <= SEL_S_WAIT;
          end
        end
        SEL_S_ISSUE: begin
          req_r.op <= store_r ? SEL_OP_WRITE : SEL_OP_READ;
          if (tsel_r) begin
            req_r.addr <= ptr_r;
            req_r.data <= gp_r;
          end else begin
            unique case (step_r)
              3'd0:    req_r.addr <= cfg_wa;
              3'd1:    req_r.addr <= cfg_wa + 6'h01;
              3'd2:    req_r.addr <= `SEL_WA_STA_LOW;
              3'd3:    req_r.addr <= `SEL_WA_STA_MID;
              default: req_r.addr <= `SEL_WA_STA_HIGH;
            endcase
            // Only the write steps use the data; read steps carry it along unused.
            req_r.data <= (step_r == 3'd0) ? config_r : base_r;
          end
          start_r <= 1'b1;
          state_r <= SEL_S_WAIT;
        end
        SEL_S_WAIT: begin
          // Each read or write done pulse before the last step advances the walk by one word.
          if (eng_done) begin
            if (req_r.op == SEL_OP_WREN) begin
              // Fixed select has no setup words to store.
              if (!tsel_r && config_select_pins_in == `SEL_SEL_FIXED) begin
                state_r <= SEL_S_FIN;
              end else begin
                state_r <= SEL_S_ISSUE;
              end
            end else if (step_r == last_step) begin
              state_r <= SEL_S_FIN;
            end else begin
              step_r  <= step_r + 3'd1;
              state_r <= SEL_S_ISSUE;
            end
          end
        end
        SEL_S_FIN: begin
          state_r <= SEL_S_IDLE;
        end
        default: begin
          state_r <= SEL_S_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Setup registers: loaded from the store or written by software
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      config_r   <= `SEL_CONFIG_RST;
      base_r     <= `SEL_BASE_RST;
      sta_low_r  <= `SEL_STA_RST;
      sta_mid_r  <= `SEL_STA_RST;
      sta_high_r <= `SEL_STA_RST;
      gp_r       <= 16'h0000;
      ptr_r      <= 6'h00;
    // A finished store read wins over a bus write; writes are blocked while busy anyway.
    end else if (eng_done && req_r.op == SEL_OP_READ) begin
      if (tsel_r) begin
        gp_r <= eng_rdata;
      end else begin
        unique case (step_r)
          3'd0:    config_r   <= eng_rdata;
          3'd1:    base_r     <= eng_rdata;
          3'd2:    sta_low_r  <= eng_rdata;
          3'd3:    sta_mid_r  <= eng_rdata;
          default: sta_high_r <= eng_rdata;
        endcase
      end
    end else if (wr_acc) begin
      unique case (paddr_in)
        `SEL_OFS_CONFIG:   config_r   <= pwdata_in[15:0];
        `SEL_OFS_BASE:     base_r     <= pwdata_in[15:0];
        `SEL_OFS_STA_LOW:  sta_low_r  <= pwdata_in[15:0];
        `SEL_OFS_STA_MID:  sta_mid_r  <= pwdata_in[15:0];
        `SEL_OFS_STA_HIGH: sta_high_r <= pwdata_in[15:0];
        `SEL_OFS_GP:       gp_r       <= pwdata_in[15:0];
        `SEL_OFS_PTR:      ptr_r      <= pwdata_in[5:0];
        default:           ;
      endcase
    end
  end

  // Setup values leave the block straight from their flops.
  assign config_out       = config_r;
  assign base_out         = base_r;
  assign station_addr_out = {sta_high_r, sta_mid_r, sta_low_r};

  // ----------------------------------------------------------------
  // Serial engine
  // ----------------------------------------------------------------
  sel_wire_engine #(
    .HALF_CYC (HALF_CYC)
  ) u_engine (
    .clk_sys_in (clk_sys_in),
    .arst_n_in  (arst_n_in),
    .start_in   (start_r),
    .req_in     (req_r),
    .nvm_do_in  (nvm_do_in),
    .pins_out   (pins),
    .rdata_out  (eng_rdata),
    .done_out   (eng_done)
  );

  // Pins are held quiet whenever no store is fitted.
  assign nvm_cs_out = pins.cs && nvm_present_pin_in;
  assign nvm_sk_out = pins.sk && nvm_present_pin_in;
  assign nvm_di_out = pins.di && nvm_present_pin_in;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Each check watches what the sequencer, the engine or the bus port drives.
  AST_TRIG_BUSY: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (psel_in && !penable_in && paddr_in == `SEL_OFS_CTRL && busy) |=> (prdata_out[2:1] == 2'b11))
    else $error("Trigger bits not both high while busy.");
  AST_NO_WR_BUSY: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (busy && !eng_done && psel_in && penable_in && pwrite_in && paddr_in == `SEL_OFS_CONFIG) |=> $stable(config_r))
    else $error("Register written while busy.");
  AST_CLEAR_DONE: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (state_r == SEL_S_FIN) |=> (!reload_r && !store_r && state_r == SEL_S_IDLE))
    else $error("Trigger not cleared at end.");
  AST_NO_ACCESS: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    !nvm_present_pin_in |-> !pins.cs)
    else $error("Store selected while absent.");
  AST_CFG_ADDR: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (start_r && !tsel_r && step_r == 3'd1 && req_r.op != SEL_OP_WREN)
    |-> (req_r.addr == {config_select_pins_in, 2'b01}))
    else $error("Base word address wrong.");
  AST_STA_ADDR: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (start_r && !tsel_r && step_r == 3'd2 && req_r.op == SEL_OP_READ) |-> (req_r.addr == `SEL_WA_STA_LOW))
    else $error("Station address word wrong.");
  AST_GP_ADDR: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (start_r && tsel_r && req_r.op != SEL_OP_WREN) |-> (req_r.addr == ptr_r))
    else $error("Pointer address not used.");
  AST_FIXED_SEL: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (start_r && !tsel_r && config_select_pins_in == `SEL_SEL_FIXED) |-> (step_r >= 3'd2 || req_r.op == SEL_OP_WREN))
    else $error("Setup word accessed with fixed select.");
  AST_CFG_WORD: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (start_r && !tsel_r && step_r == 3'd0 && req_r.op != SEL_OP_WREN)
    |-> (req_r.addr == {config_select_pins_in, 2'b00}))
    else $error("Configuration word address wrong.");
  AST_STA_MID: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (start_r && !tsel_r && step_r == 3'd3 && req_r.op == SEL_OP_READ) |-> (req_r.addr == `SEL_WA_STA_MID))
    else $error("Middle station word wrong.");
  AST_STA_HIGH: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (start_r && !tsel_r && step_r == 3'd4 && req_r.op == SEL_OP_READ) |-> (req_r.addr == `SEL_WA_STA_HIGH))
    else $error("High station word wrong.");
  AST_BLOCK_RD: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (psel_in && !penable_in && busy && paddr_in != `SEL_OFS_CTRL) |=> (prdata_out == 32'h0000_0000))
    else $error("Blocked register read returned data.");
  AST_WR_STORE: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (start_r && req_r.op == SEL_OP_WRITE) |-> store_r)
    else $error("Store write without store trigger.");
  AST_TRIG_START: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    (state_r == SEL_S_IDLE && (reload_r || store_r)) |=> busy)
    else $error("Trigger did not start an operation.");
  AST_SK_QUIET: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
    !nvm_cs_out |-> !nvm_sk_out)
    else $error("Serial clock moved outside a frame.");

endmodule : sel_setup_loader

/* File: sel_setup_loader_tb.sv */
`include "sel_defs.svh"
// ----------------------------------------------------------------
// Register-level bench with a serial store model
// ----------------------------------------------------------------
module sel_setup_loader_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys_in = 1'b0;
  logic        arst_n_in  = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, present = 1'b1, cs_bad = 1'b0;
  logic [7:0]  paddr  = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rv;
  logic [2:0]  sel    = 3'h2;
  logic        pready, pslverr, err, cs, sk, di, dout, busy;
  logic [15:0] cfg, base;
  logic [47:0] sta;
  int          n_errors = 0, comparisons = 0;

  sel_setup_loader #(.HALF_CYC(2)) i_sel_setup_loader (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .config_select_pins_in(sel),
    .nvm_present_pin_in(present), .nvm_do_in(dout), .nvm_cs_out(cs), .nvm_sk_out(sk), .nvm_di_out(di),
    .config_out(cfg), .base_out(base), .station_addr_out(sta), .busy_out(busy));
  sel_nvm_model i_sel_nvm_model (.cs_in(cs), .sk_in(sk), .di_in(di), .do_out(dout));

  // Clock at 250 MHz.
  initial begin
    forever #2 clk_sys_in = ~clk_sys_in;
  end

  // Any select activity without a fitted store is remembered.
  always @(posedge clk_sys_in) begin
    if (!present && cs) cs_bad <= 1'b1;
  end

  task automatic final_report();
    $display("mismatches %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
    comparisons++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask : chk

  // One APB transfer; an idle edge first so no strobe is driven twice in one step.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge clk_sys_in);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys_in);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys_in);
      i++;
    end while (pready !== 1'b1 && i < 20);
    rv      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (i >= 20) begin
      n_errors++;
      final_report();
    end
  endtask : apb

  // Poll the control word until both triggers have cleared.
  task automatic poll();
    int k;
    k = 0;
    do begin
      apb(1'b0, `SEL_OFS_CTRL, 32'h0);
      k++;
    end while (rv[2:1] !== 2'b00 && k < 3000);
    if (k >= 3000) begin
      n_errors++;
      final_report();
    end
  endtask : poll

  task automatic do_reset(input logic [2:0] s, input logic p);
    arst_n_in <= 1'b0;
    sel       <= s;
    present   <= p;
    repeat (5) @(posedge clk_sys_in);
    arst_n_in <= 1'b1;
  endtask : do_reset

  // Main sequence.
  initial begin
    do_reset(3'h2, 1'b1);
    apb(1'b0, `SEL_OFS_CONFIG, 32'h0);
    chk("boot refuse", 48'h1, 48'(err));
    chk("boot busy", 48'h1, 48'(busy));
    apb(1'b1, `SEL_OFS_CONFIG, 32'h7777);
    chk("busy write refuse", 48'h1, 48'(err));
    apb(1'b0, `SEL_OFS_CTRL, 32'h0);
    chk("boot triggers", 48'h3, 48'(rv[2:1]));
    poll();
    chk("boot config", 48'hC308, 48'(cfg));
    chk("boot base", 48'hC309, 48'(base));
    chk("boot station", 48'hC322_C321_C320, sta);
    chk("idle busy", 48'h0, 48'(busy));
    apb(1'b0, `SEL_OFS_STA_MID, 32'h0);
    chk("station mid", 48'hC321, 48'(rv));
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped", 48'h1, 48'(err));
    $display("test boot done");
    apb(1'b1, `SEL_OFS_PTR, 32'hEA);
    apb(1'b1, `SEL_OFS_GP, 32'h1234);
    apb(1'b1, `SEL_OFS_CTRL, 32'h5);
    apb(1'b0, `SEL_OFS_CTRL, 32'h0);
    chk("gp triggers", 48'h3, 48'(rv[2:1]));
    poll();
    apb(1'b1, `SEL_OFS_GP, 32'h0);
    apb(1'b1, `SEL_OFS_CTRL, 32'h3);
    poll();
    chk("select kept", 48'h1, 48'(rv[2:0]));
    apb(1'b0, `SEL_OFS_GP, 32'h0);
    chk("gp word", 48'h1234, 48'(rv));
    chk("gp word 2A", 48'h1234, 48'(i_sel_nvm_model.mem[6'h2A]));
    $display("test general done");
    apb(1'b1, `SEL_OFS_CONFIG, 32'hBEEF);
    apb(1'b1, `SEL_OFS_BASE, 32'h0300);
    apb(1'b1, `SEL_OFS_CTRL, 32'h4);
    poll();
    apb(1'b1, `SEL_OFS_CONFIG, 32'h0);
    apb(1'b1, `SEL_OFS_BASE, 32'h0);
    apb(1'b1, `SEL_OFS_CTRL, 32'h2);
    poll();
    chk("ctrl low bits", 48'h0, 48'(rv[2:0]));
    chk("reload config", 48'hBEEF, 48'(cfg));
    chk("reload base", 48'h0300, 48'(base));
    apb(1'b1, `SEL_OFS_CONFIG, 32'h0);
    apb(1'b1, `SEL_OFS_CTRL, 32'h6);
    poll();
    chk("reload wins", 48'hBEEF, 48'(cfg));
    chk("store skipped", 48'hBEEF, 48'(i_sel_nvm_model.mem[6'h08]));
    $display("test normal done");
    do_reset(3'h7, 1'b1);
    poll();
    chk("fixed config", 48'h0, 48'(cfg));
    chk("fixed base", 48'h0, 48'(base));
    chk("fixed station", 48'hC322_C321_C320, sta);
    $display("test fixed select done");
    do_reset(3'h2, 1'b0);
    apb(1'b1, `SEL_OFS_CTRL, 32'h2);
    apb(1'b0, `SEL_OFS_CTRL, 32'h0);
    chk("absent ctrl", 48'h0, 48'(rv[2:0]));
    chk("absent config", 48'h0, 48'(cfg));
    chk("absent select", 48'h0, 48'(cs_bad));
    $display("test absent done");
    final_report();
  end
endmodule : sel_setup_loader_tb

/* File: sel_wire_engine.sv */
`include "sel_defs.svh"

// ----------------------------------------------------------------
// Three-wire serial engine: one command per start pulse.
// ----------------------------------------------------------------
module sel_wire_engine
  import sel_pkg::*;
#(
  parameter int HALF_CYC = `SEL_HALF_CYC
) (
  input  wire logic      clk_sys_in,
  input  wire logic      arst_n_in,
  input  wire logic      start_in,
  input  wire sel_req_t  req_in,
  input  wire logic      nvm_do_in,
  output sel_pins_t      pins_out,
  output logic [15:0]    rdata_out,
  output logic           done_out
);

  typedef enum logic [2:0] {SEL_E_IDLE, SEL_E_SHIFT, SEL_E_GAP, SEL_E_BUSY, SEL_E_END} sel_est_t;

  sel_est_t    state_r;
  logic [15:0] div_r;
  logic        tick;
  logic [26:0] sr_r;
  logic [5:0]  cnt_r;
  logic        rd_r;
  logic        wr_r;

  // Divider gives a one-cycle enable per serial half period.
  assign tick = (div_r == 16'(HALF_CYC - 1));
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      div_r <= 16'h0000;
    end else if (state_r == SEL_E_IDLE || tick) begin
      div_r <= 16'h0000;
    end else begin
      div_r <= div_r + 16'h0001;
    end
  end

  // Frame: start bit, opcode, address, then 16 data bits shifted out or in; a write-enable frame ends after the address.
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_r   <= SEL_E_IDLE;
      pins_out  <= '0;
      sr_r      <= '0;
      cnt_r     <= 6'h00;
      rd_r      <= 1'b0;
      wr_r      <= 1'b0;
      rdata_out <= 16'h0000;
      done_out  <= 1'b0;
    end else begin
      done_out <= 1'b0;
      unique case (state_r)
        SEL_E_IDLE: begin
          if (start_in) begin
            rd_r  <= (req_in.op == SEL_OP_READ);
            wr_r  <= (req_in.op == SEL_OP_WRITE);
            // The start bit is set up here, so only opcode, address and data wait in the shifter.
            unique case (req_in.op)
              SEL_OP_READ:  sr_r <= {2'b10, req_in.addr, 16'h0000, 3'b000};
              SEL_OP_WRITE: sr_r <= {2'b01, req_in.addr, req_in.data, 3'b000};
              default:      sr_r <= {2'b00, 6'h30, 16'h0000, 3'b000};
            endcase
            cnt_r        <= (req_in.op == SEL_OP_WREN) ? 6'd9 : 6'd25;
            pins_out.di  <= 1'b1;
            pins_out.cs  <= 1'b1;
            state_r      <= SEL_E_SHIFT;
          end
        end
        SEL_E_SHIFT: begin
          // Data moves only as the clock falls, never with the rising edge at which the store samples it.
          if (tick) begin
            if (!pins_out.sk) begin
              if (cnt_r == 6'h00) begin
                pins_out.cs <= 1'b0;
                pins_out.di <= 1'b0;
                state_r     <= SEL_E_GAP;
              end else begin
                pins_out.sk <= 1'b1;
              end
            end else begin
              pins_out.sk <= 1'b0;
              pins_out.di <= sr_r[26];
              sr_r        <= {sr_r[25:0], 1'b0};
              cnt_r       <= cnt_r - 6'h01;
              if (rd_r && cnt_r <= 6'd16) begin
                rdata_out <= {rdata_out[14:0], nvm_do_in};
              end
            end
          end
        end
        SEL_E_GAP: begin
          // Chip select low, then back high so a write can report ready.
          if (tick) begin
            if (wr_r) begin
              pins_out.cs <= 1'b1;
              state_r     <= SEL_E_BUSY;
            end else begin
              state_r <= SEL_E_END;
            end
          end
        end
        SEL_E_BUSY: begin
          // Store drives its data pin high once the internal write has ended.
          if (tick && nvm_do_in) begin
            pins_out.cs <= 1'b0;
            state_r     <= SEL_E_END;
          end
        end
        SEL_E_END: begin
          done_out <= 1'b1;
          state_r  <= SEL_E_IDLE;
        end
      endcase
    end
  end

endmodule : sel_wire_engine
